// ==== core/bkpt_dbg_pkg.sv ====
// constants shared by the breakpoint, trigger and trace logic
// assumes a single system clock; serial pins come from outside that domain
package bkpt_dbg_pkg;
	localparam int          REG_W        = 32;
	localparam int          IDX_W        = 4;
	localparam int          STAT_W       = 4;
	localparam int          FRAME_BITS   = 37;
	localparam int          FCNT_W       = 6;
	// register indices
	localparam logic [3:0]  IDX_ADDR     = 4'h0;
	localparam logic [3:0]  IDX_ADDR_MSK = 4'h1;
	localparam logic [3:0]  IDX_DATA     = 4'h2;
	localparam logic [3:0]  IDX_DATA_MSK = 4'h3;
	localparam logic [3:0]  IDX_PC0      = 4'h4;
	localparam logic [3:0]  IDX_PC_MSK   = 4'h8;
	localparam logic [3:0]  IDX_TRIG_CTL = 4'h9;
	localparam int          NUM_REGS     = 10;
	// trigger control fields
	localparam int          TC_ENABLE    = 0;
	localparam int          TC_TWO_LVL   = 1;
	localparam int          TC_RESP_IRQ  = 2;
	localparam int          TC_L1_LSB    = 3;
	localparam int          TC_L2_LSB    = 6;
	localparam int          TC_PASS_LSB  = 9;
	localparam logic [31:0] TRIG_CTL_RST = 32'h0000_0000;
	localparam logic [3:0]  STAT_HALTED  = 4'hF;
endpackage : bkpt_dbg_pkg

// ==== core/mask_match.sv ====
// masked comparator used for every breakpoint condition
// assumes all inputs come from the same clock domain
`timescale 1ns/1ps
module mask_match #(
	parameter int W = 32
) (
	input  wire logic [W-1:0] observed_in,
	input  wire logic [W-1:0] value_in,
	input  wire logic [W-1:0] mask_in,
	output logic              hit_out
);
	// zero mask bits are don't-care
	assign hit_out = ((observed_in & mask_in) == (value_in & mask_in));
endmodule : mask_match

// ==== core/breakpoint_trace_debug.sv ====
// breakpoint registers, trigger sequencer, serial debug channel and trace port
// assumes processor signals are synchronous to clk_sys_in; serial pins are asynchronous
`timescale 1ns/1ps
module breakpoint_trace_debug #(
	parameter bit FULL_TRACE = 1'b1
) (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// serial debug channel
	input  wire logic        serial_debug_clock_in,
	input  wire logic        serial_debug_in,
	output logic             serial_debug_out,
	// supervisor register access
	input  wire logic        cpu_supervisor_in,
	input  wire logic        cpu_reg_wr_in,
	input  wire logic        cpu_reg_rd_in,
	input  wire logic [3:0]  cpu_reg_idx_in,
	input  wire logic [31:0] cpu_reg_wdata_in,
	output logic [31:0]      cpu_reg_rdata_out,
	// observed processor activity
	input  wire logic        cpu_bus_valid_in,
	input  wire logic [31:0] cpu_addr_in,
	input  wire logic [31:0] cpu_data_in,
	input  wire logic        cpu_pc_valid_in,
	input  wire logic [31:0] cpu_pc_in,
	input  wire logic [3:0]  cpu_status_in,
	input  wire logic [3:0]  cpu_ddata_in,
	// interrupt handling
	input  wire logic [2:0]  cpu_irq_level_in,
	input  wire logic        cpu_debug_exit_in,
	output logic             irq_allowed_out,
	output logic             emulator_mode_out,
	// trigger responses
	output logic             halt_request_out,
	output logic             debug_irq_out,
	// trace port
	output logic [3:0]       processor_status_bus_out,
	output logic [3:0]       debug_data_bus_out,
	output logic             trace_clock_out,
	output logic             halt_indicator_out
);
	localparam int W  = bkpt_dbg_pkg::REG_W;
	localparam int FB = bkpt_dbg_pkg::FRAME_BITS;
	localparam int FW = bkpt_dbg_pkg::FCNT_W;

	// register file and synchronisers
	logic [W-1:0]  regs_q [bkpt_dbg_pkg::NUM_REGS];
	logic [W-1:0]  regs_d [bkpt_dbg_pkg::NUM_REGS];
	logic [2:0]    sck_q;
	logic [1:0]    sdi_q;
	logic [FB-1:0] in_shift_q, in_shift_d;
	logic [W-1:0]  out_shift_q, out_shift_d;
	logic [bkpt_dbg_pkg::FCNT_W-1:0] bit_cnt_q, bit_cnt_d;
	logic [W-1:0]  rdata_q, rdata_d;
	logic          sck_rise;
	logic [FB-1:0] frame;
	logic          frame_done;

	// trigger state
	logic          armed_q, armed_d;
	logic          emu_q, emu_d;
	logic          halt_q, halt_d;
	logic          dirq_q, dirq_d;
	logic [3:0]    pst_q, pst_d;
	logic [3:0]    ddata_q, ddata_d;
	logic          tclk_q, tclk_d;

	logic          addr_hit, data_hit;
	logic [3:0]    pc_hits;
	logic [2:0]    hits, sel1, sel2;
	logic [31:0]   tctl;
	logic          lvl1, lvl2, fire;

	// serial side: clock edge found only after two sampling stages
	assign sck_rise = sck_q[1] & ~sck_q[2];
	assign frame    = {in_shift_q[FB-2:0], sdi_q[1]};
	assign frame_done = sck_rise && (bit_cnt_q == FW'(FB - 1));

	always_comb begin
		in_shift_d  = in_shift_q;
		bit_cnt_d   = bit_cnt_q;
		out_shift_d = out_shift_q;
		rdata_d     = rdata_q;
		for (int i = 0; i < bkpt_dbg_pkg::NUM_REGS; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (sck_rise) begin
			in_shift_d  = frame;
			out_shift_d = {out_shift_q[W-2:0], 1'b0};
			bit_cnt_d   = frame_done ? '0 : bit_cnt_q + 1'b1;
		end
		// supervisor access; a serial write in the same cycle wins
		if (cpu_supervisor_in && cpu_reg_wr_in &&
		    (int'(cpu_reg_idx_in) < bkpt_dbg_pkg::NUM_REGS)) begin
			regs_d[cpu_reg_idx_in] = cpu_reg_wdata_in;
		end
		if (cpu_reg_rd_in) begin
			rdata_d = (cpu_supervisor_in && (int'(cpu_reg_idx_in) < bkpt_dbg_pkg::NUM_REGS))
			          ? regs_q[cpu_reg_idx_in] : '0;
		end
		// frame: write flag, register index, data word, most significant first
		if (frame_done && (int'(frame[W+3:W]) < bkpt_dbg_pkg::NUM_REGS)) begin
			if (frame[FB-1]) begin
				regs_d[frame[W+3:W]] = frame[W-1:0];
			end else begin
				out_shift_d = regs_q[frame[W+3:W]];
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sck_q       <= '0;
			sdi_q       <= '0;
			in_shift_q  <= '0;
			out_shift_q <= '0;
			bit_cnt_q   <= '0;
			rdata_q     <= '0;
			for (int i = 0; i < bkpt_dbg_pkg::NUM_REGS; i++) begin
				regs_q[i] <= '0;
			end
			regs_q[bkpt_dbg_pkg::IDX_TRIG_CTL] <= bkpt_dbg_pkg::TRIG_CTL_RST;
		end else begin
			sck_q       <= {sck_q[1:0], serial_debug_clock_in};
			sdi_q       <= {sdi_q[0], serial_debug_in};
			in_shift_q  <= in_shift_d;
			out_shift_q <= out_shift_d;
			bit_cnt_q   <= bit_cnt_d;
			rdata_q     <= rdata_d;
			for (int i = 0; i < bkpt_dbg_pkg::NUM_REGS; i++) begin
				regs_q[i] <= regs_d[i];
			end
		end
	end

	assign serial_debug_out  = out_shift_q[W-1];
	assign cpu_reg_rdata_out = rdata_q;

	// comparators
	mask_match #(.W(W)) u_addr (
		.observed_in (cpu_addr_in),
		.value_in    (regs_q[bkpt_dbg_pkg::IDX_ADDR]),
		.mask_in     (regs_q[bkpt_dbg_pkg::IDX_ADDR_MSK]),
		.hit_out     (addr_hit)
	);
	mask_match #(.W(W)) u_data (
		.observed_in (cpu_data_in),
		.value_in    (regs_q[bkpt_dbg_pkg::IDX_DATA]),
		.mask_in     (regs_q[bkpt_dbg_pkg::IDX_DATA_MSK]),
		.hit_out     (data_hit)
	);
	for (genvar g = 0; g < 4; g++) begin : g_pc
		mask_match #(.W(W)) u_pc (
			.observed_in (cpu_pc_in),
			.value_in    (regs_q[int'(bkpt_dbg_pkg::IDX_PC0) + g]),
			.mask_in     (regs_q[bkpt_dbg_pkg::IDX_PC_MSK]),
			.hit_out     (pc_hits[g])
		);
	end

	assign tctl = regs_q[bkpt_dbg_pkg::IDX_TRIG_CTL];
	assign hits = {cpu_pc_valid_in & (|pc_hits),
	               cpu_bus_valid_in & data_hit,
	               cpu_bus_valid_in & addr_hit};
	assign sel1 = tctl[bkpt_dbg_pkg::TC_L1_LSB +: 3];
	assign sel2 = tctl[bkpt_dbg_pkg::TC_L2_LSB +: 3];
	// a level fires when every selected condition matches; empty selection never fires
	assign lvl1 = (sel1 != 3'h0) && ((hits & sel1) == sel1);
	assign lvl2 = (sel2 != 3'h0) && ((hits & sel2) == sel2);
	assign fire = tctl[bkpt_dbg_pkg::TC_ENABLE] &&
	              (tctl[bkpt_dbg_pkg::TC_TWO_LVL] ? (armed_q && lvl2) : lvl1);

	always_comb begin
		armed_d = armed_q;
		emu_d   = emu_q;
		halt_d  = 1'b0;
		dirq_d  = 1'b0;
		if (!tctl[bkpt_dbg_pkg::TC_ENABLE] || !tctl[bkpt_dbg_pkg::TC_TWO_LVL]) begin
			armed_d = 1'b0;
		end else if (fire) begin
			armed_d = 1'b0;
		end else if (lvl1) begin
			armed_d = 1'b1;
		end
		if (fire) begin
			halt_d = ~tctl[bkpt_dbg_pkg::TC_RESP_IRQ];
			dirq_d = tctl[bkpt_dbg_pkg::TC_RESP_IRQ];
		end
		if (cpu_debug_exit_in) begin
			emu_d = 1'b0;
		end
		// entry wins over an exit in the same cycle so no debug event is lost
		if (dirq_q) begin
			emu_d = 1'b1;
		end
		pst_d   = cpu_status_in;
		ddata_d = cpu_ddata_in;
		tclk_d  = ~tclk_q;
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			armed_q <= 1'b0;
			emu_q   <= 1'b0;
			halt_q  <= 1'b0;
			dirq_q  <= 1'b0;
			pst_q   <= '0;
			ddata_q <= '0;
			tclk_q  <= 1'b0;
		end else begin
			armed_q <= armed_d;
			emu_q   <= emu_d;
			halt_q  <= halt_d;
			dirq_q  <= dirq_d;
			pst_q   <= pst_d;
			ddata_q <= ddata_d;
			tclk_q  <= tclk_d;
		end
	end

	assign halt_request_out  = halt_q;
	assign debug_irq_out     = dirq_q;
	assign emulator_mode_out = emu_q;
	// outside emulator mode nothing is held back; inside, only levels at or above threshold
	assign irq_allowed_out = ~emu_q ||
	                         (cpu_irq_level_in >= tctl[bkpt_dbg_pkg::TC_PASS_LSB +: 3]);

	// small packages lose the parallel buses but keep the halt indicator
	assign processor_status_bus_out = FULL_TRACE ? pst_q : 4'h0;
	assign debug_data_bus_out       = FULL_TRACE ? ddata_q : 4'h0;
	assign trace_clock_out          = FULL_TRACE ? tclk_q : 1'b0;
	assign halt_indicator_out       = &pst_q;
endmodule : breakpoint_trace_debug

// ==== dv/serial_tool.sv ====
// debug tool model: 37-bit frames MSB first, serial clock idles low
// assumes the device samples the serial pins with its own system clock
`timescale 1ns/1ps
module serial_tool (
	// link pins
	output logic      ser_clk_out,
	output logic      ser_data_out,
	input  wire logic ser_data_in
);
	initial begin
		ser_clk_out  = 1'b0;
		ser_data_out = 1'b1;
	end
	// answer of the previous frame is sampled just before each of the first 32 rises
	task automatic xfer(input logic [36:0] frame, output logic [31:0] rd);
		for (int i = 36; i >= 0; i--) begin
			ser_data_out = frame[i];
			#160;
			if (i > 4) rd[i-5] = ser_data_in;
			ser_clk_out = 1'b1;
			#160;
			ser_clk_out = 1'b0;
		end
		// data line has a pull-up, so it rests high between frames
		ser_data_out = 1'b1;
	endtask : xfer
endmodule : serial_tool

// ==== dv/breakpoint_trace_debug_asserts.sv ====
// port-level properties of trace, trigger pulses and register reads
// assumes full trace (default parameter) and one clock domain
`timescale 1ns/1ps
module breakpoint_trace_debug_asserts (
	input wire logic        clk_sys_in,
	input wire logic        reset_n_in,
	input wire logic        cpu_reg_rd_in,
	input wire logic        cpu_supervisor_in,
	input wire logic [3:0]  cpu_status_in,
	input wire logic [3:0]  cpu_ddata_in,
	input wire logic        cpu_debug_exit_in,
	input wire logic [31:0] cpu_reg_rdata_out,
	input wire logic        irq_allowed_out,
	input wire logic        emulator_mode_out,
	input wire logic        halt_request_out,
	input wire logic        debug_irq_out,
	input wire logic [3:0]  processor_status_bus_out,
	input wire logic [3:0]  debug_data_bus_out,
	input wire logic        trace_clock_out,
	input wire logic        halt_indicator_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	halt_ind_a: assert property (halt_indicator_out == &processor_status_bus_out)
		else $error("halt indicator not the and of status");
	status_copy_a: assert property ($past(reset_n_in) |->
		processor_status_bus_out == $past(cpu_status_in)) else $error("status bus not copied");
	ddata_copy_a: assert property ($past(reset_n_in) |->
		debug_data_bus_out == $past(cpu_ddata_in)) else $error("data bus not copied");
	trace_toggle_a: assert property ($past(reset_n_in) |-> $changed(trace_clock_out))
		else $error("trace clock did not toggle");
	halt_pulse_a: assert property (halt_request_out |=> !halt_request_out)
		else $error("halt request longer than one cycle");
	one_response_a: assert property (!(halt_request_out && debug_irq_out))
		else $error("both trigger responses at once");
	emul_enter_a: assert property (debug_irq_out |=> emulator_mode_out)
		else $error("emulator mode not entered");
	emul_exit_a: assert property (cpu_debug_exit_in && !debug_irq_out |=> !emulator_mode_out)
		else $error("emulator mode not left");
	irq_open_a: assert property (!emulator_mode_out |-> irq_allowed_out)
		else $error("interrupt blocked outside emulator mode");
	user_read_a: assert property (cpu_reg_rd_in && !cpu_supervisor_in |=>
		cpu_reg_rdata_out == 32'h0000_0000) else $error("user read returned data");
	rdata_hold_a: assert property ($past(reset_n_in) && !$past(cpu_reg_rd_in) |->
		$stable(cpu_reg_rdata_out)) else $error("read data moved without a read");
endmodule : breakpoint_trace_debug_asserts
bind breakpoint_trace_debug breakpoint_trace_debug_asserts breakpoint_trace_debug_asserts_i (
	.clk_sys_in               (clk_sys_in),
	.reset_n_in               (reset_n_in),
	.cpu_reg_rd_in            (cpu_reg_rd_in),
	.cpu_supervisor_in        (cpu_supervisor_in),
	.cpu_status_in            (cpu_status_in),
	.cpu_ddata_in             (cpu_ddata_in),
	.cpu_debug_exit_in        (cpu_debug_exit_in),
	.cpu_reg_rdata_out        (cpu_reg_rdata_out),
	.irq_allowed_out          (irq_allowed_out),
	.emulator_mode_out        (emulator_mode_out),
	.halt_request_out         (halt_request_out),
	.debug_irq_out            (debug_irq_out),
	.processor_status_bus_out (processor_status_bus_out),
	.debug_data_bus_out       (debug_data_bus_out),
	.trace_clock_out          (trace_clock_out),
	.halt_indicator_out       (halt_indicator_out)
);

// ==== dv/breakpoint_trace_debug_test.sv ====
// self-checking bench: registers, serial channel, triggers and trace port
// assumes the serial tool model and the bound checker
`timescale 1ns/1ps
`define chk(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module breakpoint_trace_debug_test;
	logic clk_sys_in = 1'b0, reset_n_in = 1'b0, sclk, sdi, so, sup = 1'b1, wr = 1'b0;
	logic rd = 1'b0, bv = 1'b0, pv = 1'b0, ex = 1'b0, emu, irq_ok, halt, dirq, tclk, hind;
	logic [3:0] idx = 4'h0, st = 4'h0, dd = 4'h0, psb, ddb;
	logic [2:0] lvl = 3'h0;
	logic [31:0] wd = 32'h0, ad = 32'h0, pc = 32'h0, dt = 32'h0, rdata, r;
	int bad_count = 0, checked = 0, cycles = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	serial_tool tool_i (.ser_clk_out(sclk), .ser_data_out(sdi), .ser_data_in(so));
	breakpoint_trace_debug breakpoint_trace_debug_i (.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in), .serial_debug_clock_in(sclk), .serial_debug_in(sdi),
		.serial_debug_out(so), .cpu_supervisor_in(sup), .cpu_reg_wr_in(wr), .cpu_reg_rd_in(rd),
		.cpu_reg_idx_in(idx), .cpu_reg_wdata_in(wd), .cpu_reg_rdata_out(rdata),
		.cpu_bus_valid_in(bv), .cpu_addr_in(ad), .cpu_data_in(dt),
		.cpu_pc_valid_in(pv), .cpu_pc_in(pc), .cpu_status_in(st), .cpu_ddata_in(dd),
		.cpu_irq_level_in(lvl), .cpu_debug_exit_in(ex), .irq_allowed_out(irq_ok),
		.emulator_mode_out(emu), .halt_request_out(halt), .debug_irq_out(dirq),
		.processor_status_bus_out(psb), .debug_data_bus_out(ddb), .trace_clock_out(tclk),
		.halt_indicator_out(hind));
	task automatic tick; @(posedge clk_sys_in); #1; endtask : tick
	task automatic cpu_wr(input logic [3:0] i, input logic [31:0] d);
		idx = i; wd = d; wr = 1'b1; tick; wr = 1'b0; tick;
	endtask : cpu_wr
	task automatic cpu_rd(input logic [3:0] i, output logic [31:0] d);
		idx = i; rd = 1'b1; tick; rd = 1'b0; d = rdata; tick;
	endtask : cpu_rd
	task automatic t_regs;
		for (int i = 0; i < 10; i++) cpu_wr(4'(i), 32'h5A00_C300 + 32'(i));
		for (int i = 0; i < 10; i++) begin
			cpu_rd(4'(i), r);
			`chk("reg", 32'h5A00_C300 + 32'(i), r)
		end
		sup = 1'b0; cpu_wr(4'h0, 32'hFFFF_FFFF); cpu_rd(4'h0, r);
		`chk("user read", 32'h0000_0000, r)
		sup = 1'b1; cpu_rd(4'h0, r);
		`chk("user write", 32'h5A00_C300, r)
	endtask : t_regs
	task automatic t_serial;
		tool_i.xfer({1'b1, 4'h2, 32'h1234_ABCD}, r); tick; cpu_rd(4'h2, r);
		`chk("serial write", 32'h1234_ABCD, r)
		cpu_wr(4'h6, 32'hFEDC_0123); tool_i.xfer({1'b0, 4'h6, 32'h0}, r);
		tool_i.xfer({1'b0, 4'hF, 32'h0}, r);
		`chk("serial read", 32'hFEDC_0123, r)
	endtask : t_serial
	task automatic t_trig;
		cpu_wr(4'h8, 32'hFFFF_FF00); cpu_wr(4'h5, 32'h0000_1200); cpu_wr(4'h9, 32'h0000_0021);
		pc = 32'h0000_13AB; pv = 1'b1; tick; `chk("masked miss", 1'b0, halt)
		pc = 32'h0000_12AB; tick; `chk("halt", 1'b1, halt)
		pv = 1'b0; tick; `chk("halt end", 1'b0, halt)
		cpu_wr(4'h9, 32'h0000_0625); lvl = 3'h2; pv = 1'b1; tick;
		`chk("debug irq", 1'b1, dirq)
		pv = 1'b0; tick; `chk("emulator", 1'b1, emu)
		`chk("low irq", 1'b0, irq_ok)
		lvl = 3'h3; tick; `chk("critical irq", 1'b1, irq_ok)
		ex = 1'b1; tick; ex = 1'b0; tick; `chk("exit", 1'b0, emu)
	endtask : t_trig
	task automatic t_two;
		cpu_wr(4'h0, 32'h0000_4000); cpu_wr(4'h1, 32'hFFFF_FFFF); cpu_wr(4'h9, 32'h0000_010B);
		pv = 1'b1; tick; `chk("unarmed", 1'b0, halt)
		pv = 1'b0; ad = 32'h0000_4000; bv = 1'b1; tick; `chk("first level", 1'b0, halt)
		bv = 1'b0; pv = 1'b1; tick; `chk("second level", 1'b1, halt)
		pv = 1'b0; tick; pv = 1'b1; tick; `chk("disarmed", 1'b0, halt)
		pv = 1'b0;
		// single level needing both address and data, the data under a byte mask
		cpu_wr(4'h2, 32'h0000_00A5); cpu_wr(4'h3, 32'h0000_00FF); cpu_wr(4'h9, 32'h0000_0019);
		dt = 32'h0000_00A4; bv = 1'b1; tick; `chk("data miss", 1'b0, halt)
		dt = 32'hFFFF_FFA5; tick; `chk("addr and data", 1'b1, halt)
		bv = 1'b0; tick; `chk("both end", 1'b0, halt)
	endtask : t_two
	task automatic t_trace;
		logic t0;
		st = 4'hF; dd = 4'h9; tick; `chk("status", 4'hF, psb)
		`chk("data", 4'h9, ddb)
		`chk("halted", 1'b1, hind)
		st = 4'hE; t0 = tclk; tick; `chk("running", 1'b0, hind)
		`chk("trace clock", ~t0, tclk)
	endtask : t_trace
	task automatic t_reset;
		cpu_rd(4'h9, r); `chk("ctl before reset", 32'h0000_0019, r)
		reset_n_in = 1'b0; tick; `chk("reset halt", 1'b0, halt)
		`chk("reset emulator", 1'b0, emu)
		`chk("reset status", 4'h0, psb)
		`chk("reset rdata", 32'h0000_0000, rdata)
		reset_n_in = 1'b1; cpu_rd(4'h9, r);
		`chk("ctl reset", bkpt_dbg_pkg::TRIG_CTL_RST, r)
		cpu_rd(4'h0, r); `chk("addr reset", 32'h0000_0000, r)
	endtask : t_reset
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys_in);
		#1 reset_n_in = 1'b1;
		t_regs; t_serial; t_trig; t_two; t_trace; t_reset;
		tally_and_finish;
	end
endmodule : breakpoint_trace_debug_test
